// ---- hw/prog_lock_pkg.sv ----
// shared constants and carrier types for the program-store write lock block
package prog_lock_pkg;
	localparam logic [7:0] LOCK_KEY_ADDR = 8'hb7;
	localparam logic [7:0] PROG_CTRL_ADDR = 8'hf5;
	localparam logic [7:0] STORE_CTRL_ADDR = 8'h8f;
	localparam logic [7:0] KEY_FIRST = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int PROG_EN_POS = 7;
	localparam int HW_DIS_POS = 6;
	localparam int STORE_WE_POS = 0;

	typedef enum logic [1:0] {
		LK_LOCKED = 2'b00,
		LK_FIRST = 2'b01,
		LK_OPEN = 2'b10,
		LK_DEAD = 2'b11
	} lock_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef struct packed {
		logic rd_valid;
		logic [7:0] rdata;
	} sfr_rsp_s;
endpackage

// ---- hw/prog_lock.sv ----
// key sequencer, lock state and programming control registers for the program store
//
// Summary of operation
// - key A5 then F1 permits one write
// - permission withdrawn after one completed write
// - wrong or out-of-order key locks permanently
// - write with write-enable set while not permitted locks permanently
// - read bits 1:0: 00 locked, 01 first
// - 10 writes allowed, 11 disabled until reset
// - bit 7 enables in-application programming
// - bit 6 disables discharge, frees pin
// - control bits 5:0 read zero, ignore writes
// - store write only with write-enable bit set
`timescale 1ns/10ps
module prog_lock (
	input wire logic clk,
	input wire logic rst,
	input prog_lock_pkg::sfr_req_s req,
	output prog_lock_pkg::sfr_rsp_s rsp,
	input wire logic store_wr_req,
	input wire logic store_wr_done,
	output logic store_wr_go,
	output logic store_write_enable,
	output logic prog_enable_bit,
	output logic discharge_hw_disable
);
	import prog_lock_pkg::*;

	// whole register image of the block, one flop stage for everything
	typedef struct packed {
		lock_state_e lock;
		logic we;
		logic pen;
		logic hwd;
		logic go;
		logic busy;
		sfr_rsp_s rsp;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	// decoded write strobes of this cycle
	logic key_wr;
	logic ctrl_wr;
	logic store_ctrl_wr;

	// store write handshake terms
	logic attempt;
	logic permitted;
	logic launch;
	logic forbidden;
	logic finishing;
	lock_state_e key_lock;

	// write strobe aimed at one register address
	function automatic logic is_write(input sfr_req_s r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// next lock state after one write to the key register
	function automatic lock_state_e key_step(input lock_state_e cur, input logic [7:0] data);
		lock_state_e n;
		n = LK_DEAD;
		unique case (cur)
			LK_LOCKED: begin
				if (data == KEY_FIRST) begin
					n = LK_FIRST;
				end else begin
					n = LK_DEAD;
				end
			end
			LK_FIRST: begin
				if (data == KEY_SECOND) begin
					n = LK_OPEN;
				end else begin
					n = LK_DEAD;
				end
			end
			LK_OPEN: begin
				// a key write while unlocked is out of order
				n = LK_DEAD;
			end
			LK_DEAD: begin
				// only a device reset leaves this state
				n = LK_DEAD;
			end
		endcase
		return n;
	endfunction

	// store activity applied on top of the key write result
	function automatic lock_state_e lock_step(input lock_state_e k, input logic bad, input logic spent);
		lock_state_e n;
		n = k;
		if (bad) begin
			n = LK_DEAD;
		end else if (spent && k == LK_OPEN) begin
			// a key fault in the same cycle wins over spending the permission
			n = LK_LOCKED;
		end
		return n;
	endfunction

	// busy spans from the go pulse to the done pulse of the memory
	function automatic logic busy_step(input logic b, input logic start, input logic stop);
		logic n;
		n = b;
		if (start) begin
			n = 1'b1;
		end else if (stop) begin
			n = 1'b0;
		end
		return n;
	endfunction

	// lock state sits in the two lowest bits of the key register
	function automatic logic [7:0] lock_image(input lock_state_e l);
		logic [7:0] v;
		v = REG_RESET;
		v[1:0] = l;
		return v;
	endfunction

	// only the two control bits exist, the rest reads zero
	function automatic logic [7:0] ctrl_image(input logic pen, input logic hwd);
		logic [7:0] v;
		v = REG_RESET;
		v[PROG_EN_POS] = pen;
		v[HW_DIS_POS] = hwd;
		return v;
	endfunction

	// store control keeps just the write-enable bit
	function automatic logic [7:0] store_image(input logic we);
		logic [7:0] v;
		v = REG_RESET;
		v[STORE_WE_POS] = we;
		return v;
	endfunction

	// read data for one address, zero where nothing is mapped
	function automatic logic [7:0] read_mux(input logic [7:0] a, input state_s s);
		logic [7:0] v;
		v = REG_RESET;
		unique case (a)
			LOCK_KEY_ADDR: begin
				v = lock_image(s.lock);
			end
			PROG_CTRL_ADDR: begin
				v = ctrl_image(s.pen, s.hwd);
			end
			STORE_CTRL_ADDR: begin
				v = store_image(s.we);
			end
			default: begin
				v = REG_RESET;
			end
		endcase
		return v;
	endfunction

	assign key_wr = is_write(req, LOCK_KEY_ADDR);
	assign ctrl_wr = is_write(req, PROG_CTRL_ADDR);
	assign store_ctrl_wr = is_write(req, STORE_CTRL_ADDR);

	// a store write only reaches memory with write-enable set, one at a time
	assign attempt = store_wr_req && st_r.we && !st_r.busy;
	// key writes of this same cycle are taken into account first
	assign key_lock = key_wr ? key_step(st_r.lock, req.wdata) : st_r.lock;
	assign permitted = (st_r.lock == LK_OPEN) && (key_lock == LK_OPEN);
	assign launch = attempt && permitted;
	assign forbidden = attempt && !permitted;
	assign finishing = st_r.busy && store_wr_done;

	always_comb begin
		st_nxt = st_r;

		// read response stands for exactly one cycle after the strobe
		if (req.rd) begin
			st_nxt.rsp.rd_valid = 1'b1;
			st_nxt.rsp.rdata = read_mux(req.addr, st_r);
		end else begin
			st_nxt.rsp.rd_valid = 1'b0;
			st_nxt.rsp.rdata = REG_RESET;
		end

		// lock state: key write first, then store activity on top
		st_nxt.lock = lock_step(key_lock, forbidden, finishing);

		// programming control register; bits 5:0 are not stored
		if (ctrl_wr) begin
			st_nxt.pen = req.wdata[PROG_EN_POS];
			st_nxt.hwd = req.wdata[HW_DIS_POS];
		end

		// store control register
		if (store_ctrl_wr) begin
			st_nxt.we = req.wdata[STORE_WE_POS];
		end

		// one-cycle go pulse and busy flag for the memory handshake
		st_nxt.go = launch;
		st_nxt.busy = busy_step(st_r.busy, launch, finishing);
	end

	// synchronous reset clears the permanent lock as well
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// every output is a field of the registered image
	assign rsp = st_r.rsp;
	assign store_wr_go = st_r.go;
	assign store_write_enable = st_r.we;
	assign prog_enable_bit = st_r.pen;
	assign discharge_hw_disable = st_r.hwd;
endmodule

// ---- tb/prog_lock_properties.sv ----
// concurrent checks on the ports of the program-store write lock block
`timescale 1ns/10ps
module prog_lock_properties (
	input wire logic clk,
	input wire logic rst,
	input prog_lock_pkg::sfr_req_s req,
	input prog_lock_pkg::sfr_rsp_s rsp,
	input wire logic store_wr_req,
	input wire logic store_wr_go,
	input wire logic store_write_enable,
	input wire logic prog_enable_bit,
	input wire logic discharge_hw_disable
);
	import prog_lock_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_go_once: assert property (store_wr_go |=> !store_wr_go) else $error("go pulse too long");
	chk_go_req: assert property (store_wr_go |-> $past(store_wr_req)) else $error("go without request");
	chk_go_we: assert property (store_wr_go |-> $past(store_write_enable)) else $error("go without enable");
	chk_rd_valid: assert property (rsp.rd_valid == $past(req.rd)) else $error("read valid timing");
	chk_rd_idle: assert property (!rsp.rd_valid |-> rsp.rdata == 8'h00) else $error("read data not idle");
	chk_rst_clear: assert property ($past(rst) |-> !store_wr_go && !prog_enable_bit && !store_write_enable
		&& !discharge_hw_disable) else $error("outputs not cleared by reset");
	chk_en_hold: assert property (!req.wr |=> $stable(prog_enable_bit)) else $error("enable changed");
	chk_we_hold: assert property (!req.wr |=> $stable(store_write_enable)) else $error("write enable changed");
	chk_hwd_hold: assert property (!req.wr |=> $stable(discharge_hw_disable)) else $error("disable changed");
	chk_ctrl_low: assert property (rsp.rd_valid && $past(req.addr) == PROG_CTRL_ADDR |-> rsp.rdata[5:0] == 6'h00)
		else $error("control low bits not zero");
	chk_lock_code: assert property (rsp.rd_valid && $past(req.addr) == LOCK_KEY_ADDR |-> rsp.rdata[7:2] == 6'h00)
		else $error("lock upper bits not zero");
endmodule
bind prog_lock prog_lock_properties chk(.*);

// ---- tb/prog_lock_tb.sv ----
// bench for the program-store write lock block
`timescale 1ns/10ps
module prog_lock_tb;
	import prog_lock_pkg::*;

	localparam int CYCLE_LIMIT = 900;
	// 1 us at 40 ns per cycle
	localparam int SETTLE_CYCLES = 25;

	logic clk;
	logic rst;
	logic wr_try;
	logic wr_done;
	logic wr_go;
	logic we_out;
	logic pen_out;
	logic hwd_out;
	sfr_req_s req;
	sfr_rsp_s rsp;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;

	prog_lock prog_lock_inst (
		.clk(clk),
		.rst(rst),
		.req(req),
		.rsp(rsp),
		.store_wr_req(wr_try),
		.store_wr_done(wr_done),
		.store_wr_go(wr_go),
		.store_write_enable(we_out),
		.prog_enable_bit(pen_out),
		.discharge_hw_disable(hwd_out)
	);

	initial begin
		clk = 1'b0;
		forever begin
			#20 clk = ~clk;
		end
	end

	task automatic conclude();
		if (miscompares == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT) begin
			miscompares = miscompares + 1;
			conclude();
		end
	end

	task automatic check(input string what, input logic [7:0] expected, input logic [7:0] seen);
		comparisons++;
		if (seen !== expected) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, expected, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic reg_read(input string what, input logic [7:0] addr, input logic [7:0] expected);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		check(what, expected, rsp.rdata);
		check({what, " valid"}, 8'h01, {7'h00, rsp.rd_valid});
	endtask

	task automatic store_try(input logic expect_go);
		@(posedge clk);
		wr_try <= 1'b1;
		@(posedge clk);
		wr_try <= 1'b0;
		@(negedge clk);
		check("store go", {7'h00, expect_go}, {7'h00, wr_go});
	endtask

	task automatic store_finish();
		@(posedge clk);
		wr_done <= 1'b1;
		@(posedge clk);
		wr_done <= 1'b0;
	endtask

	task automatic apply_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
	endtask

	task automatic check_outputs(input logic pen, input logic hwd, input logic we);
		@(negedge clk);
		check("prog enable", {7'h00, pen}, {7'h00, pen_out});
		check("discharge disable", {7'h00, hwd}, {7'h00, hwd_out});
		check("store write enable", {7'h00, we}, {7'h00, we_out});
	endtask

	initial begin
		rst = 1'b1;
		req = '0;
		wr_try = 1'b0;
		wr_done = 1'b0;
		apply_reset();
		check_outputs(1'b0, 1'b0, 1'b0);
		reg_read("lock after reset", LOCK_KEY_ADDR, 8'h00);
		reg_write(LOCK_KEY_ADDR, KEY_FIRST);
		reg_read("lock first key", LOCK_KEY_ADDR, 8'h01);
		reg_write(LOCK_KEY_ADDR, KEY_SECOND);
		reg_read("lock open", LOCK_KEY_ADDR, 8'h02);
		reg_write(STORE_CTRL_ADDR, 8'h01);
		reg_read("store control", STORE_CTRL_ADDR, 8'h01);
		check_outputs(1'b0, 1'b0, 1'b1);
		store_try(1'b1);
		store_try(1'b0);
		store_finish();
		reg_read("lock spent", LOCK_KEY_ADDR, 8'h00);
		store_try(1'b0);
		reg_read("lock after bad store", LOCK_KEY_ADDR, 8'h03);
		reg_write(LOCK_KEY_ADDR, KEY_FIRST);
		reg_read("lock stays dead", LOCK_KEY_ADDR, 8'h03);
		repeat (SETTLE_CYCLES) @(posedge clk);
		reg_write(PROG_CTRL_ADDR, 8'hff);
		reg_read("prog control", PROG_CTRL_ADDR, 8'hc0);
		check_outputs(1'b1, 1'b1, 1'b1);
		reg_write(PROG_CTRL_ADDR, 8'h40);
		check_outputs(1'b0, 1'b1, 1'b1);
		apply_reset();
		check_outputs(1'b0, 1'b0, 1'b0);
		reg_read("lock cleared", LOCK_KEY_ADDR, 8'h00);
		store_try(1'b0);
		reg_read("lock ignores disabled store", LOCK_KEY_ADDR, 8'h00);
		reg_write(LOCK_KEY_ADDR, KEY_FIRST);
		reg_write(LOCK_KEY_ADDR, KEY_FIRST);
		reg_read("lock out of order", LOCK_KEY_ADDR, 8'h03);
		apply_reset();
		reg_write(LOCK_KEY_ADDR, 8'h11);
		reg_read("lock forced", LOCK_KEY_ADDR, 8'h03);
		reg_read("unmapped read", 8'h00, 8'h00);
		conclude();
	end
endmodule
